//--- verilog/hbasp_top.v
`include "hbasp_defs.vh"
module hbasp_top #(
  parameter FIFO_DEPTH = 8,
  parameter FIFO_AW    = 3
) (
  input  wire       core_clk,
  input  wire       rst_b,
  input  wire       chip_select_low,
  input  wire       read_strobe_low,
  input  wire       write_strobe_low,
  input  wire       reg_select,
  input  wire [7:0] data_in,
  output reg  [7:0] data_out,
  output wire       data_oe_low,
  output wire       irq_out_low,
  output wire       irq_oe_low,
  input  wire       rx_line,
  output reg        tx_line,
  input  wire       ext_clk16,
  input  wire       ctl_pin_one_low,
  input  wire       ctl_pin_two_low_in,
  output wire       ctl_pin_two_low_out,
  output wire       ctl_pin_two_low_oe_low
);
  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  reg [2:0] s_cs_q, s_rd_q, s_wr_q, s_rs_q, s_rx_q, s_ek_q, s_c1_q, s_c2_q;
  reg [7:0] s_d0_q, s_d1_q;
  reg cs_q, rd_q, wr_q, rs_q, rx_q, ek_q, c1_q, c2_q;

  function agree_upd;
    input [2:0] s;
    input       old;
    begin
      agree_upd = (s[1] == s[2]) ? s[2] : old;
    end
  endfunction

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_cs_q <= 3'h7; s_rd_q <= 3'h7; s_wr_q <= 3'h7; s_rs_q <= 3'h0;
      s_rx_q <= 3'h7; s_ek_q <= 3'h0; s_c1_q <= 3'h7; s_c2_q <= 3'h7;
      s_d0_q <= 8'h00; s_d1_q <= 8'h00;
      cs_q <= 1'b1; rd_q <= 1'b1; wr_q <= 1'b1; rs_q <= 1'b0;
      rx_q <= 1'b1; ek_q <= 1'b0; c1_q <= 1'b1; c2_q <= 1'b1;
    end else begin
      s_cs_q <= {s_cs_q[1:0], chip_select_low};
      s_rd_q <= {s_rd_q[1:0], read_strobe_low};
      s_wr_q <= {s_wr_q[1:0], write_strobe_low};
      s_rs_q <= {s_rs_q[1:0], reg_select};
      s_rx_q <= {s_rx_q[1:0], rx_line};
      s_ek_q <= {s_ek_q[1:0], ext_clk16};
      s_c1_q <= {s_c1_q[1:0], ctl_pin_one_low};
      s_c2_q <= {s_c2_q[1:0], ctl_pin_two_low_in};
      s_d0_q <= data_in;
      s_d1_q <= s_d0_q;
      cs_q <= agree_upd(s_cs_q, cs_q);
      rd_q <= agree_upd(s_rd_q, rd_q);
      wr_q <= agree_upd(s_wr_q, wr_q);
      rs_q <= agree_upd(s_rs_q, rs_q);
      rx_q <= agree_upd(s_rx_q, rx_q);
      ek_q <= agree_upd(s_ek_q, ek_q);
      c1_q <= agree_upd(s_c1_q, c1_q);
      c2_q <= agree_upd(s_c2_q, c2_q);
    end
  end

  // ------------------------------------------------------------
  // Host access decode
  // ------------------------------------------------------------
  reg        wr_d1_q, rd_d1_q, ek_d1_q;
  reg [7:0]  mode_q, mask_q, baud_q, ctl_q;
  reg [3:0]  seq_q;
  reg        soft_rst_q;
  // Write taken on the rising edge of the strobe; data has long settled
  wire sel     = !cs_q;
  wire wr_done = sel && wr_q && !wr_d1_q;
  wire rd_done = sel && rd_q && !rd_d1_q;
  wire rd_act  = sel && !rd_q;
  wire wr_lo   = wr_done && !rs_q;
  wire wr_ctl  = wr_done && rs_q;
  wire [7:0] wdat = s_d1_q;
  wire clr = soft_rst_q;

  assign data_oe_low = !rd_act;

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_d1_q <= 1'b1; rd_d1_q <= 1'b1; ek_d1_q <= 1'b0;
      ctl_q <= `HBASP_RST_BYTE; soft_rst_q <= 1'b0;
    end else begin
      wr_d1_q <= wr_q; rd_d1_q <= rd_q; ek_d1_q <= ek_q;
      if (wr_ctl) begin
        ctl_q <= wdat;
        soft_rst_q <= wdat[`HBASP_CTL_RESET];
      end
    end
  end

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      seq_q <= `HBASP_SEQ_MODE;
      mode_q <= `HBASP_RST_BYTE; mask_q <= `HBASP_RST_BYTE; baud_q <= `HBASP_RST_BYTE;
    end else if (clr) begin
      seq_q <= `HBASP_SEQ_MODE;
    end else if (wr_lo) begin
      case (seq_q)
        `HBASP_SEQ_MODE: begin
          mode_q <= wdat;
          seq_q  <= `HBASP_SEQ_MASK;
        end
        `HBASP_SEQ_MASK: begin
          mask_q <= wdat;
          seq_q  <= `HBASP_SEQ_BAUD;
        end
        `HBASP_SEQ_BAUD: begin
          baud_q <= wdat;
          seq_q  <= `HBASP_SEQ_DATA;
        end
        `HBASP_SEQ_DATA: begin
          seq_q <= `HBASP_SEQ_DATA;
        end
        default: begin
          seq_q <= `HBASP_SEQ_MODE;
        end
      endcase
    end
  end

  wire ready = (seq_q == `HBASP_SEQ_DATA) && !clr;
  wire [7:0] tx_wr_data = wdat;
  wire tx_push = wr_lo && (seq_q == `HBASP_SEQ_DATA);

  // ------------------------------------------------------------
  // Baud generator: one-cycle 16x tick
  // ------------------------------------------------------------
  reg [12:0] bdiv_q;
  reg        tick_q;
  // Divisors rescaled to this core clock; lookup indexed by baud select
  function [12:0] baud_div;
    input [3:0] sel4;
    begin
      case (sel4)
        4'h0: baud_div = 13'h30d3;
        4'h1: baud_div = 13'h162e;
        4'h2: baud_div = 13'h1225;
        4'h3: baud_div = 13'h1046;
        4'h4: baud_div = 13'h0822;
        4'h5: baud_div = 13'h0411;
        4'h6: baud_div = 13'h0208;
        4'h7: baud_div = 13'h015b;
        4'h8: baud_div = 13'h0137;
        4'h9: baud_div = 13'h0104;
        4'ha: baud_div = 13'h00ad;
        4'hb: baud_div = 13'h0081;
        4'hc: baud_div = 13'h0056;
        4'hd: baud_div = 13'h0040;
        4'he: baud_div = 13'h001f;
        default: baud_div = 13'h000f;
      endcase
    end
  endfunction

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      bdiv_q <= 13'h0000; tick_q <= 1'b0;
    end else if (mode_q[`HBASP_MODE_EXT_CLK]) begin
      bdiv_q <= 13'h0000;
      tick_q <= ek_q && !ek_d1_q;
    end else if (bdiv_q >= baud_div(baud_q[3:0])) begin
      bdiv_q <= 13'h0000; tick_q <= 1'b1;
    end else begin
      bdiv_q <= bdiv_q + 13'h0001; tick_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Transmit path
  // ------------------------------------------------------------
  wire [7:0] txf_data;
  wire       txf_valid;
  wire       txf_in_ready;
  reg        tx_busy_q, tx_done_q;
  reg [3:0]  tx_os_q, tx_bits_q;
  reg [10:0] tx_sh_q;
  wire len8   = mode_q[`HBASP_MODE_LEN8];
  wire par_en = mode_q[`HBASP_MODE_PAR_EN];
  wire par_od = mode_q[`HBASP_MODE_PAR_ODD];
  wire cts_ok = mode_q[`HBASP_MODE_CP1_GP] || !c1_q;
  wire tx_load = ready && !tx_busy_q && txf_valid && cts_ok && tick_q;

  hbasp_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_txf (
    .core_clk  (core_clk),
    .rst_b     (rst_b),
    .flush     (clr),
    .in_data   (tx_wr_data),
    .in_valid  (tx_push),
    .in_ready  (txf_in_ready),
    .out_data  (txf_data),
    .out_valid (txf_valid),
    .out_ready (tx_load)
  );

  function par_of;
    input [7:0] d;
    input       l8;
    input       odd;
    begin
      par_of = ^(l8 ? d : {1'b0, d[6:0]}) ^ odd;
    end
  endfunction

  wire [7:0] txd = len8 ? txf_data : {1'b0, txf_data[6:0]};
  wire       txp = par_of(txf_data, len8, par_od);

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_busy_q <= 1'b0; tx_done_q <= 1'b0; tx_line <= 1'b1;
      tx_os_q <= 4'h0; tx_bits_q <= 4'h0; tx_sh_q <= 11'h7ff;
    end else if (clr) begin
      tx_busy_q <= 1'b0; tx_line <= 1'b1;
      tx_done_q <= 1'b0;
    end else if (tx_load) begin
      if (rd_done && rs_q) tx_done_q <= 1'b0;
      tx_busy_q <= 1'b1; tx_line <= 1'b0; tx_os_q <= 4'h0;
      // Frame after start: data, optional parity, stop bits, padded with mark
      if (len8 && par_en) tx_sh_q <= {2'b11, txp, txd};
      else if (len8) tx_sh_q <= {3'b111, txd};
      else if (par_en) tx_sh_q <= {3'b111, txp, txd[6:0]};
      else tx_sh_q <= {4'hf, txd[6:0]};
      tx_bits_q <= 4'h8 + {3'h0, len8} + {3'h0, par_en}
                   + {3'h0, mode_q[`HBASP_MODE_STOP2]};
    end else if (tx_busy_q && tick_q) begin
      if (rd_done && rs_q) tx_done_q <= 1'b0;
      tx_os_q <= tx_os_q + 4'h1;
      if (tx_os_q == `HBASP_OS_LAST) begin
        if (tx_bits_q == 4'h0) begin
          tx_busy_q <= 1'b0; tx_done_q <= 1'b1; tx_line <= 1'b1;
        end else begin
          tx_line <= tx_sh_q[0];
          tx_sh_q <= {1'b1, tx_sh_q[10:1]};
          tx_bits_q <= tx_bits_q - 4'h1;
        end
      end
    end else if (rd_done && rs_q) begin
      tx_done_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Receive path
  // ------------------------------------------------------------
  localparam RX_IDLE = 4'h1, RX_START = 4'h2, RX_DATA = 4'h4, RX_STOP = 4'h8;
  reg [3:0] rx_st_q, rx_os_q, rx_n_q;
  reg [8:0] rx_sh_q;
  reg [7:0] rx_hold_q;
  reg       rx_rdy_q, par_err_q, ovr_err_q, frm_err_q, rx_prev_q;
  wire [3:0] rx_need = 4'h6 + {3'h0, len8} + {3'h0, par_en};
  wire [7:0] rx_dat = len8 ? rx_sh_q[7:0] : {1'b0, rx_sh_q[6:0]};
  wire rx_pbit = len8 ? rx_sh_q[8] : rx_sh_q[7];
  wire rd_data = rd_done && !rs_q;

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_st_q <= RX_IDLE; rx_os_q <= 4'h0; rx_n_q <= 4'h0; rx_sh_q <= 9'h000;
      rx_hold_q <= 8'h00; rx_rdy_q <= 1'b0; par_err_q <= 1'b0;
      ovr_err_q <= 1'b0; frm_err_q <= 1'b0; rx_prev_q <= 1'b1;
    end else if (!ready) begin
      rx_st_q <= RX_IDLE; rx_rdy_q <= 1'b0; rx_prev_q <= 1'b1;
      par_err_q <= 1'b0; ovr_err_q <= 1'b0; frm_err_q <= 1'b0;
    end else begin
      rx_prev_q <= rx_q;
      // Host read clears flags; a new character in the same cycle wins
      if (rd_data) begin
        rx_rdy_q <= 1'b0; ovr_err_q <= 1'b0;
      end
      if (rd_done && rs_q) begin
        par_err_q <= 1'b0; frm_err_q <= 1'b0;
      end
      case (rx_st_q)
        RX_IDLE: begin
          if (rx_prev_q && !rx_q) begin
            rx_st_q <= RX_START; rx_os_q <= 4'h0;
          end
        end
        RX_START: begin
          if (tick_q) begin
            rx_os_q <= rx_os_q + 4'h1;
            if (rx_os_q == `HBASP_OS_MID) begin
              rx_st_q <= rx_q ? RX_IDLE : RX_DATA;
              rx_os_q <= 4'h0; rx_n_q <= 4'h0;
            end
          end
        end
        RX_DATA: begin
          if (tick_q) begin
            rx_os_q <= rx_os_q + 4'h1;
            if (rx_os_q == `HBASP_OS_LAST) begin
              rx_sh_q[rx_n_q] <= rx_q;
              rx_n_q <= rx_n_q + 4'h1;
              if (rx_n_q == rx_need) rx_st_q <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (tick_q) begin
            rx_os_q <= rx_os_q + 4'h1;
            if (rx_os_q == `HBASP_OS_LAST) begin
              rx_st_q <= RX_IDLE;
              rx_hold_q <= rx_dat;
              rx_rdy_q <= 1'b1;
              if (rx_rdy_q && !rd_data) ovr_err_q <= 1'b1;
              if (!rx_q) frm_err_q <= 1'b1;
              if (par_en && (par_of(rx_dat, len8, par_od) != rx_pbit))
                par_err_q <= 1'b1;
            end
          end
        end
        default: rx_st_q <= RX_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Status, read data, interrupt, control pins
  // ------------------------------------------------------------
  wire cp2_in = mode_q[`HBASP_MODE_CP2_IN];
  wire [7:0] status;
  assign status[`HBASP_ST_CP1]      = !c1_q;
  assign status[`HBASP_ST_CP2]      = cp2_in ? !c2_q : 1'b0;
  assign status[`HBASP_ST_RX_RDY]   = rx_rdy_q;
  assign status[`HBASP_ST_TX_EMPTY] = txf_in_ready && ready;
  assign status[`HBASP_ST_PAR_ERR]  = par_err_q;
  assign status[`HBASP_ST_OVR_ERR]  = ovr_err_q;
  assign status[`HBASP_ST_FRM_ERR]  = frm_err_q;
  assign status[`HBASP_ST_TX_DONE]  = tx_done_q;

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      data_out <= 8'h00;
    end else if (rd_act) begin
      data_out <= rs_q ? status : rx_hold_q;
    end
  end

  assign irq_out_low = 1'b0;
  assign irq_oe_low  = !(|(status[7:2] & mask_q[7:2]));

  assign ctl_pin_two_low_out    = !ctl_q[`HBASP_CTL_CP2];
  assign ctl_pin_two_low_oe_low = cp2_in;
endmodule

//--- verilog/hbasp_defs.vh
`ifndef HBASP_DEFS_VH
`define HBASP_DEFS_VH
// ------------------------------------------------------------
// Write steering after reset
// ------------------------------------------------------------
`define HBASP_SEQ_MODE      4'h1
`define HBASP_SEQ_MASK      4'h2
`define HBASP_SEQ_BAUD      4'h4
`define HBASP_SEQ_DATA      4'h8
// ------------------------------------------------------------
// Control word fields
// ------------------------------------------------------------
`define HBASP_CTL_RESET     7
`define HBASP_CTL_CP2       0
// ------------------------------------------------------------
// Mode word fields
// ------------------------------------------------------------
`define HBASP_MODE_CP1_GP   0
`define HBASP_MODE_CP2_IN   1
`define HBASP_MODE_CP2_GP   2
`define HBASP_MODE_EXT_CLK  3
`define HBASP_MODE_LEN8     4
`define HBASP_MODE_STOP2    5
`define HBASP_MODE_PAR_EN   6
`define HBASP_MODE_PAR_ODD  7
// ------------------------------------------------------------
// Status word fields
// ------------------------------------------------------------
`define HBASP_ST_CP1        0
`define HBASP_ST_CP2        1
`define HBASP_ST_RX_RDY     2
`define HBASP_ST_TX_EMPTY   3
`define HBASP_ST_PAR_ERR    4
`define HBASP_ST_OVR_ERR    5
`define HBASP_ST_FRM_ERR    6
`define HBASP_ST_TX_DONE    7
// ------------------------------------------------------------
// Reset values and timing
// ------------------------------------------------------------
`define HBASP_RST_BYTE      8'h00
`define HBASP_OS_MID        4'h7
`define HBASP_OS_LAST       4'hf
`define HBASP_CLK_HZ        10000000
`define HBASP_EXT_MAX_BAUD  100000
`define HBASP_EXT_MIN_HALF  ((`HBASP_CLK_HZ / (`HBASP_EXT_MAX_BAUD * 32)))
`endif

//--- verilog/hbasp_fifo.v
module hbasp_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             core_clk,
  input  wire             rst_b,
  input  wire             flush,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_q;
  reg [AW-1:0]    rd_q;
  reg [AW:0]      cnt_q;
  wire            push;
  wire            pop;

  assign in_ready  = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data  = mem[rd_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always @(posedge core_clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_q  <= {AW{1'b0}};
      rd_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else if (flush) begin
      wr_q  <= {AW{1'b0}};
      rd_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule

//--- sim/hbasp_top_assertions.sv
module hbasp_top_assertions #(
  parameter FIFO_DEPTH = 8,
  parameter FIFO_AW    = 3
) (
  input wire       core_clk,
  input wire       rst_b,
  input wire       chip_select_low,
  input wire       read_strobe_low,
  input wire       write_strobe_low,
  input wire       reg_select,
  input wire [7:0] data_in,
  input wire [7:0] data_out,
  input wire       data_oe_low,
  input wire       irq_out_low,
  input wire       irq_oe_low,
  input wire       rx_line,
  input wire       tx_line,
  input wire       ext_clk16,
  input wire       ctl_pin_one_low,
  input wire       ctl_pin_two_low_in,
  input wire       ctl_pin_two_low_out,
  input wire       ctl_pin_two_low_oe_low
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);
  // ----------------------------------------
  // Cycles since a selected write ended
  // ----------------------------------------
  logic       wr_q;
  logic [3:0] age_q;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_q  <= 1'b1;
      age_q <= 4'hf;
    end else begin
      wr_q <= write_strobe_low;
      if (write_strobe_low && !wr_q && !chip_select_low) begin
        age_q <= 4'h0;
      end else if (age_q != 4'hf) begin
        age_q <= age_q + 4'h1;
      end
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  a_cs_release: assert property (chip_select_low [*5] |-> data_oe_low)
    else $error("bus driven while deselected");
  a_rd_release: assert property (read_strobe_low [*5] |-> data_oe_low)
    else $error("bus driven without read strobe");
  a_rd_drives: assert property ((!chip_select_low && !read_strobe_low) [*6] |-> !data_oe_low)
    else $error("selected read not driven");
  a_oe_fall: assert property ($fell(data_oe_low) |->
    !$past(chip_select_low, 2) && !$past(read_strobe_low, 2))
    else $error("bus driven without selected read");
  a_oe_rise: assert property ($rose(data_oe_low) |->
    $past(chip_select_low, 2) || $past(read_strobe_low, 2) || !$past(rst_b))
    else $error("bus released during read");
  a_rst_idle: assert property ($rose(rst_b) |-> tx_line && data_oe_low && irq_oe_low)
    else $error("outputs not idle after reset");
  a_irq_drain: assert property (!irq_oe_low |-> !irq_out_low)
    else $error("interrupt pin driven high");
  a_cp2_write: assert property ($changed(ctl_pin_two_low_out) ||
    $changed(ctl_pin_two_low_oe_low) |-> age_q < 4'h9)
    else $error("pin two changed without write");
  c_read: cover property ($fell(data_oe_low));
  c_irq: cover property ($fell(irq_oe_low));
  c_tx: cover property ($fell(tx_line));
endmodule

bind hbasp_top hbasp_top_assertions #(.FIFO_DEPTH(FIFO_DEPTH), .FIFO_AW(FIFO_AW)) u_chk (
  .core_clk(core_clk), .rst_b(rst_b), .chip_select_low(chip_select_low),
  .read_strobe_low(read_strobe_low), .write_strobe_low(write_strobe_low),
  .reg_select(reg_select), .data_in(data_in), .data_out(data_out),
  .data_oe_low(data_oe_low), .irq_out_low(irq_out_low), .irq_oe_low(irq_oe_low),
  .rx_line(rx_line), .tx_line(tx_line), .ext_clk16(ext_clk16),
  .ctl_pin_one_low(ctl_pin_one_low), .ctl_pin_two_low_in(ctl_pin_two_low_in),
  .ctl_pin_two_low_out(ctl_pin_two_low_out),
  .ctl_pin_two_low_oe_low(ctl_pin_two_low_oe_low));

//--- sim/hbasp_peer.sv
module hbasp_peer (
  input  wire  core_clk,
  input  wire  tx_line,
  output logic rx_line
);
  timeunit 1ns;
  timeprecision 1ns;
  // Sixteen ticks of eight clocks each; bench stretches it for slow rates
  int          bit_len = 128;
  int          nbits = 10;
  logic [11:0] got[$];
  logic [11:0] v;
  initial rx_line = 1'b1;
  // ----------------------------------------
  // Frame sender, LSB first, mark between frames
  // ----------------------------------------
  task automatic send(input logic [11:0] f, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge core_clk);
      rx_line <= f[i];
      repeat (bit_len - 1) @(posedge core_clk);
    end
    @(posedge core_clk);
    rx_line <= 1'b1;
  endtask
  // ----------------------------------------
  // Frame receiver, samples mid bit
  // ----------------------------------------
  always begin
    @(negedge tx_line);
    repeat (bit_len / 2) @(posedge core_clk);
    v = 12'hfff;
    for (int i = 0; i < nbits; i++) begin
      v[i] = tx_line;
      if (i < nbits - 1) begin
        repeat (bit_len) @(posedge core_clk);
      end
    end
    got.push_back(v);
  end
endmodule

//--- sim/hbasp_top_tb_top.sv
module hbasp_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic       core_clk = 1'b0;
  logic       rst_b = 1'b0;
  logic       cs_low = 1'b1;
  logic       rd_low = 1'b1;
  logic       wr_low = 1'b1;
  logic       rs = 1'b0;
  logic [7:0] host_d = 8'h00;
  logic       cp1_low = 1'b1;
  logic       cp2_low = 1'b1;
  logic [2:0] ext_cnt = 3'h0;
  int         err_total = 0;
  int         checked = 0;
  int         cycles = 0;
  wire  [7:0] data_out;
  wire        data_oe_low, irq_out_low, irq_oe_low, rx_line, tx_line;
  wire        cp2_out, cp2_oe_low;
  wire  [7:0] bus = !data_oe_low ? data_out : host_d;
  wire        irq_pin = irq_oe_low ? 1'b1 : irq_out_low;
  wire        cp2_pin = !cp2_oe_low ? cp2_out : cp2_low;

  initial forever #50 core_clk = ~core_clk;
  always @(posedge core_clk) ext_cnt <= ext_cnt + 3'h1;

  hbasp_top #(.FIFO_DEPTH(8), .FIFO_AW(3)) u_dut (
    .core_clk(core_clk), .rst_b(rst_b), .chip_select_low(cs_low),
    .read_strobe_low(rd_low), .write_strobe_low(wr_low), .reg_select(rs),
    .data_in(bus), .data_out(data_out), .data_oe_low(data_oe_low),
    .irq_out_low(irq_out_low), .irq_oe_low(irq_oe_low), .rx_line(rx_line),
    .tx_line(tx_line), .ext_clk16(ext_cnt[2]), .ctl_pin_one_low(cp1_low),
    .ctl_pin_two_low_in(cp2_pin), .ctl_pin_two_low_out(cp2_out),
    .ctl_pin_two_low_oe_low(cp2_oe_low));
  hbasp_peer u_peer (.core_clk(core_clk), .tx_line(tx_line), .rx_line(rx_line));
  // ----------------------------------------
  // Host bus and helper tasks
  // ----------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic sel, input logic [7:0] d);
    cs_low <= 1'b0;
    rs <= sel;
    host_d <= d;
    tick(4);
    wr_low <= 1'b0;
    tick(4);
    wr_low <= 1'b1;
    tick(4);
    cs_low <= 1'b1;
    tick(2);
  endtask
  task automatic rd(input logic sel, output logic [7:0] v);
    cs_low <= 1'b0;
    rs <= sel;
    tick(2);
    rd_low <= 1'b0;
    tick(7);
    @(negedge core_clk);
    v = bus;
    chk(data_oe_low, 1'b0);
    tick(1);
    rd_low <= 1'b1;
    tick(5);
    cs_low <= 1'b1;
    tick(2);
  endtask
  task automatic cfg(input logic [7:0] mode, input logic [7:0] mask, input int n);
    wr(1'b1, 8'h80);
    wr(1'b1, 8'h00);
    wr(1'b0, mode);
    wr(1'b0, mask);
    wr(1'b0, 8'h0f);
    u_peer.nbits = n;
  endtask
  task automatic wait_irq();
    for (int k = 0; k < 2000 && irq_pin !== 1'b0; k++) tick(1);
    chk(irq_pin, 1'b0);
  endtask
  task automatic get(output logic [11:0] f);
    for (int k = 0; k < 3000 && u_peer.got.size() == 0; k++) tick(1);
    f = (u_peer.got.size() > 0) ? u_peer.got.pop_front() : 12'h000;
  endtask
  function automatic logic [11:0] mk(input logic [7:0] d, input logic l8, pe, od);
    mk = 12'hfff;
    mk[0] = 1'b0;
    for (int i = 0; i < 7 + l8; i++) mk[i + 1] = d[i];
    if (pe) mk[8 + l8] = ^(d & {l8, 7'h7f}) ^ od;
  endfunction
  task automatic wrap_up();
    $display("checks=%0d errors=%0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Ceiling about two and a half times the expected run
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 70000) begin
      err_total++;
      wrap_up();
    end
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    logic [11:0] f;
    logic [7:0]  s;
    int          k;
    tick(4);
    rst_b <= 1'b1;
    tick(4);
    chk(tx_line, 1'b1);
    rd_low <= 1'b0;
    tick(8);
    chk(data_oe_low, 1'b1);
    rd_low <= 1'b1;
    tick(4);
    cfg(8'h19, 8'h84, 10);
    wr(1'b0, 8'ha5);
    get(f);
    chk(f, mk(8'ha5, 1'b1, 1'b0, 1'b0));
    wait_irq();
    rd(1'b1, s);
    chk(s & 8'h88, 8'h88);
    tick(4);
    chk(irq_pin, 1'b1);
    fork
      begin
        u_peer.send(mk(8'h3c, 1'b1, 1'b0, 1'b0), 10);
        u_peer.send(mk(8'hc3, 1'b1, 1'b0, 1'b0), 10);
      end
      begin
        wait_irq();
        rd(1'b0, s);
        chk(s, 8'h3c);
      end
    join
    wait_irq();
    rd(1'b0, s);
    chk(s, 8'hc3);
    rd(1'b1, s);
    chk(s & 8'h24, 8'h00);
    u_peer.send(mk(8'h01, 1'b1, 1'b0, 1'b0), 10);
    u_peer.send(mk(8'h02, 1'b1, 1'b0, 1'b0), 10);
    tick(40);
    rd(1'b1, s);
    chk(s & 8'h24, 8'h24);
    rd(1'b0, s);
    cfg(8'h59, 8'h00, 11);
    wr(1'b0, 8'h5b);
    get(f);
    chk(f, mk(8'h5b, 1'b1, 1'b1, 1'b0));
    u_peer.send(mk(8'h11, 1'b1, 1'b1, 1'b0) ^ 12'h200, 11);
    tick(40);
    rd(1'b1, s);
    chk(s & 8'h70, 8'h10);
    rd(1'b0, s);
    u_peer.send(mk(8'h11, 1'b1, 1'b1, 1'b0) & 12'hbff, 11);
    tick(40);
    rd(1'b1, s);
    chk(s & 8'h70, 8'h40);
    rd(1'b0, s);
    cfg(8'he9, 8'h00, 11);
    wr(1'b0, 8'h55);
    get(f);
    chk(f, mk(8'h55, 1'b0, 1'b1, 1'b1));
    u_peer.send(mk(8'h2b, 1'b0, 1'b1, 1'b1), 11);
    tick(40);
    chk(irq_pin, 1'b1);
    rd(1'b0, s);
    chk(s & 8'h7f, 8'h2b);
    // Pin one holds transmit off so the buffer fills
    cfg(8'h18, 8'h00, 10);
    wr(1'b1, 8'h01);
    chk({cp2_oe_low, cp2_out}, 2'b00);
    rd(1'b1, s);
    chk(s & 8'h01, 8'h00);
    for (k = 0; k < 12; k++) begin
      rd(1'b1, s);
      if (s[3] !== 1'b1) break;
      wr(1'b0, 8'h30 + k);
    end
    chk(k, 12'h008);
    chk(tx_line, 1'b1);
    cp1_low <= 1'b0;
    for (int j = 0; j < k; j++) begin
      get(f);
      chk(f, mk(8'h30 + j, 1'b1, 1'b0, 1'b0));
    end
    // Internal generator, fastest entry: sixteen clocks per tick
    cfg(8'h11, 8'h00, 10);
    u_peer.bit_len = 256;
    wr(1'b0, 8'h96);
    get(f);
    chk(f, mk(8'h96, 1'b1, 1'b0, 1'b0));
    cfg(8'h1a, 8'h00, 10);
    cp2_low <= 1'b0;
    rd(1'b1, s);
    chk({cp2_oe_low, s[1:0]}, 3'h7);
    wrap_up();
  end
endmodule
